/* File: hw/pwmt_top.sv */
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "pwmt_regs.svh"
// How it works
// - Four channels, 8-bit counter, period, duty.
// - Period and duty buffered until rollover/disable.
// - Counter write loads buffered values immediately.
// - Period match ends period; duty match toggles.
// - Bits 7 and 6 join channel pairs.
// - Joined pair clocked by low-order channel source.
// - High byte on channel 1/3; pin 2/4.
// - High counter read freezes low byte one cycle.
// - Joined low counter write clears all; high ignored.
// - Clock A is E divided by 1..8.
// - Clock B is E over two-to-field.
// - Clock S: scale match, clear, divide by two.
// - Channels 3/4 choose S or B.
// - Channels 1/2 choose S or A.
// - Polarity picks start level; duty flips it.
// - Clock register layout; bit 3 reads zero.
// - Polarity register layout, resets to zero.
// - Enable gates clock, forces pin output.
// - Scale value zero divides by 256.
// - Duty zero or duty above period: constant.
module pwmt_top
    import pwmt_pkg::*;
#(
    parameter int CH_W = 8
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // Register port
    input  wire pwmt_bus_t  bus_req,
    output logic [7:0]      rd_data,
    // Port pins
    output logic [3:0]      wave_out,
    output logic [3:0]      wave_oe
);

    if (CH_W != `PWMT_DATA_W) begin : g_chk
        $error("pwmt_top: channel width must match the byte-wide register map");
    end

    // Software registers
    pwmt_byte_t       clk_sel_q;
    pwmt_byte_t       pol_q;
    pwmt_byte_t       scale_q;
    logic [3:0]       en_q;
    pwmt_byte_t       per_w_q [4];
    pwmt_byte_t       dty_w_q [4];
    pwmt_byte_t       rd_data_q;
    logic [3:0]       wave_q;
    logic [3:0]       oe_q;

    // Clock generation state
    logic [`PWMT_PRESC_W-1:0] presc_q;
    pwmt_byte_t       sc_cnt_q;
    logic             sc_tog_q;

    // Per-channel views
    logic [3:0]       src_tick;
    logic [3:0]       ch_tick;
    logic [3:0]       cnt_wr;
    logic [3:0]       wave_d;
    logic [3:0]       oe_d;
    pwmt_byte_t       cnt_v [4];

    // Address decode
    wire [7:0]        base_ctl  = `PWMT_OFS_CLK;
    wire [7:0]        base_cnt  = `PWMT_OFS_CNT0;
    wire [7:0]        base_per  = `PWMT_OFS_PER0;
    wire [7:0]        base_dty  = `PWMT_OFS_DTY0;
    wire [1:0]        idx       = bus_req.addr[1:0];
    wire              is_ctl    = bus_req.addr[7:2] == base_ctl[7:2];
    wire              is_cnt    = bus_req.addr[7:2] == base_cnt[7:2];
    wire              is_per    = bus_req.addr[7:2] == base_per[7:2];
    wire              is_dty    = bus_req.addr[7:2] == base_dty[7:2];
    wire              wr_clk    = bus_req.wr && bus_req.addr == `PWMT_OFS_CLK;
    wire              wr_pol    = bus_req.wr && bus_req.addr == `PWMT_OFS_POL;
    wire              wr_scale  = bus_req.wr && bus_req.addr == `PWMT_OFS_SCALE;
    wire              wr_en     = bus_req.wr && bus_req.addr == `PWMT_OFS_EN;

    // Control register read view; bit 3 of the clock register is not stored
    wire pwmt_byte_t  ctl_v [4];
    assign ctl_v[0] = clk_sel_q & `PWMT_CLK_RD_MASK;
    assign ctl_v[1] = pol_q;
    assign ctl_v[2] = scale_q;
    assign ctl_v[3] = {4'h0, en_q};

    wire pwmt_byte_t  rd_mux = is_cnt ? cnt_v[idx]   :
                               is_per ? per_w_q[idx] :
                               is_dty ? dty_w_q[idx] :
                               is_ctl ? ctl_v[idx]   : `PWMT_RST_ZERO;

    // Prescaler taps: a tap for E/2^n fires when the low n bits are all ones
    wire [1:0]        pcka   = clk_sel_q[`PWMT_CLK_PCKA_LSB +: 2];
    wire [2:0]        pckb   = clk_sel_q[`PWMT_CLK_PCKB_LSB +: 3];
    wire [`PWMT_PRESC_W-1:0] mask_a = `PWMT_PRESC_W'((1 << pcka) - 1);
    wire [`PWMT_PRESC_W-1:0] mask_b = `PWMT_PRESC_W'((1 << pckb) - 1);
    wire              tick_a = (presc_q & mask_a) == mask_a;
    wire              tick_b = (presc_q & mask_b) == mask_b;

    // Scaled clock; a zero scale wraps the compare at 255, giving 256
    wire pwmt_byte_t  sc_last  = scale_q - 8'h01;
    wire              sc_match = tick_a && sc_cnt_q == sc_last;
    wire              tick_s   = sc_match && sc_tog_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            presc_q  <= '0;
            sc_cnt_q <= `PWMT_RST_ZERO;
            sc_tog_q <= 1'b0;
        end else begin
            presc_q <= presc_q + `PWMT_PRESC_W'(1);
            if (sc_match) begin
                sc_cnt_q <= `PWMT_RST_ZERO;
                sc_tog_q <= ~sc_tog_q;
            end else if (tick_a) begin
                sc_cnt_q <= sc_cnt_q + 8'h01;
            end
        end
    end

    // Register writes
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            clk_sel_q <= `PWMT_RST_ZERO;
            pol_q     <= `PWMT_RST_ZERO;
            scale_q   <= `PWMT_RST_ZERO;
            en_q      <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                per_w_q[i] <= `PWMT_RST_PER;
                dty_w_q[i] <= `PWMT_RST_DTY;
            end
        end else begin
            if (wr_clk) begin
                clk_sel_q <= bus_req.wdata & `PWMT_CLK_RD_MASK;
            end
            if (wr_pol) begin
                pol_q <= bus_req.wdata;
            end
            if (wr_scale) begin
                scale_q <= bus_req.wdata;
            end
            if (wr_en) begin
                en_q <= bus_req.wdata[3:0];
            end
            if (bus_req.wr && is_per) begin
                per_w_q[idx] <= bus_req.wdata;
            end
            if (bus_req.wr && is_dty) begin
                dty_w_q[idx] <= bus_req.wdata;
            end
        end
    end

    // Channel clock selection and gating
    for (genvar i = 0; i < 4; i++) begin : g_ch
        wire sel_s = pol_q[`PWMT_POL_SRC_LSB + i];
        if (i < 2) begin : g_lo
            assign src_tick[i] = sel_s ? tick_s : tick_a;
        end else begin : g_hi
            assign src_tick[i] = sel_s ? tick_s : tick_b;
        end
        // Ticks are single-cycle pulses, so gating never cuts one short
        assign ch_tick[i] = en_q[i] && src_tick[i];
        assign cnt_wr[i]  = bus_req.wr && is_cnt && idx == 2'(i);
    end

    // Channel pairs: high byte is the even index, low byte the odd index
    for (genvar p = 0; p < 2; p++) begin : g_pair
        localparam int H = 2 * p;
        localparam int L = 2 * p + 1;

        wire         joined = clk_sel_q[`PWMT_CLK_JOIN_LO + p];
        wire [15:0]  per_w  = {per_w_q[H], per_w_q[L]};
        wire [15:0]  dty_w  = {dty_w_q[H], dty_w_q[L]};
        logic [15:0] cnt_q;
        logic [15:0] cnt_d;
        logic [15:0] per_q;
        logic [15:0] per_d;
        logic [15:0] dty_q;
        logic [15:0] dty_d;
        logic [7:0]  snap_q;
        logic        hold_q;
        logic [1:0]  start8;

        wire roll16  = cnt_q == per_q;
        wire start16 = cnt_q < dty_q || dty_q >= per_q;
        wire hold_d  = joined && bus_req.rd && is_cnt && idx == 2'(H);

        always_comb begin
            logic roll8;
            roll8 = 1'b0;
            cnt_d = cnt_q;
            per_d = per_q;
            dty_d = dty_q;
            if (joined) begin
                // Clock and enable come from the low-order channel
                if (cnt_wr[L] || !en_q[L] || (ch_tick[L] && roll16)) begin
                    per_d = per_w;
                    dty_d = dty_w;
                end
                if (cnt_wr[L]) begin
                    cnt_d = 16'h0000;
                end else if (ch_tick[L]) begin
                    cnt_d = roll16 ? 16'h0000 : cnt_q + 16'h0001;
                end
            end else begin
                for (int b = 0; b < 2; b++) begin
                    roll8 = cnt_q[8*b +: 8] == per_q[8*b +: 8];
                    if (cnt_wr[L-b] || !en_q[L-b] || (ch_tick[L-b] && roll8)) begin
                        per_d[8*b +: 8] = per_w[8*b +: 8];
                        dty_d[8*b +: 8] = dty_w[8*b +: 8];
                    end
                    if (cnt_wr[L-b]) begin
                        cnt_d[8*b +: 8] = 8'h00;
                    end else if (ch_tick[L-b]) begin
                        cnt_d[8*b +: 8] = roll8 ? 8'h00 : cnt_q[8*b +: 8] + 8'h01;
                    end
                end
            end
        end

        for (genvar b = 0; b < 2; b++) begin : g_byte
            assign start8[b] = cnt_q[8*b +: 8] < dty_q[8*b +: 8] ||
                               dty_q[8*b +: 8] >= per_q[8*b +: 8];
        end

        // Start level equals the polarity bit; the duty match inverts it
        assign wave_d[L] = (joined ? start16 : start8[0]) ~^ pol_q[L];
        assign wave_d[H] = start8[1] ~^ pol_q[H];
        assign oe_d[L]   = en_q[L];
        assign oe_d[H]   = en_q[H] && !joined;
        assign cnt_v[H]  = cnt_q[15:8];
        assign cnt_v[L]  = hold_q ? snap_q : cnt_q[7:0];

        always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
                cnt_q  <= 16'h0000;
                per_q  <= {`PWMT_RST_PER, `PWMT_RST_PER};
                dty_q  <= {`PWMT_RST_DTY, `PWMT_RST_DTY};
                snap_q <= `PWMT_RST_ZERO;
                hold_q <= 1'b0;
            end else begin
                cnt_q  <= cnt_d;
                per_q  <= per_d;
                dty_q  <= dty_d;
                snap_q <= cnt_q[7:0];
                hold_q <= hold_d;
            end
        end
    end

    // Output flops; pins driven only while their channel owns them
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rd_data_q <= `PWMT_RST_ZERO;
            wave_q    <= 4'h0;
            oe_q      <= 4'h0;
        end else begin
            rd_data_q <= bus_req.rd ? rd_mux : `PWMT_RST_ZERO;
            wave_q    <= wave_d;
            oe_q      <= oe_d;
        end
    end

    assign rd_data  = rd_data_q;
    assign wave_out = wave_q;
    assign wave_oe  = oe_q;

endmodule

/* File: hw/pwmt_regs.svh */
`ifndef PWMT_REGS_SVH
`define PWMT_REGS_SVH

// Register byte offsets
`define PWMT_OFS_CLK      8'h60
`define PWMT_OFS_POL      8'h61
`define PWMT_OFS_SCALE    8'h62
`define PWMT_OFS_EN       8'h63
`define PWMT_OFS_CNT0     8'h64
`define PWMT_OFS_PER0     8'h68
`define PWMT_OFS_DTY0     8'h6C

// Clock select fields
`define PWMT_CLK_JOIN_LO  6
`define PWMT_CLK_JOIN_HI  7
`define PWMT_CLK_PCKA_LSB 4
`define PWMT_CLK_PCKB_LSB 0
`define PWMT_CLK_RD_MASK  8'hF7

// Polarity/source fields
`define PWMT_POL_SRC_LSB  4
`define PWMT_POL_POL_LSB  0

// Reset values
`define PWMT_RST_ZERO     8'h00
`define PWMT_RST_PER      8'hFF
`define PWMT_RST_DTY      8'hFF

// Widths
`define PWMT_DATA_W       8
`define PWMT_PRESC_W      7

`endif

/* File: hw/pwmt_pkg.sv */
package pwmt_pkg;

    // Register port request, one cycle per access
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pwmt_bus_t;

    typedef logic [7:0] pwmt_byte_t;

endpackage

/* File: tb/pwmt_top_monitor.sv */
`timescale 1ns/1ps
`include "pwmt_regs.svh"
module pwmt_monitor
    import pwmt_pkg::*;
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_b,
    // Register port and pins
    input wire pwmt_bus_t  bus_req,
    input wire logic [7:0] rd_data,
    input wire logic [3:0] wave_out,
    input wire logic [3:0] wave_oe
);
    logic [7:0] mir_q [16];
    logic [1:0] st_q;
    wire  [3:0] a      = bus_req.addr[3:0];
    wire        hit    = bus_req.addr[7:4] == 4'h6;
    wire  [7:0] msk    = (a == 4'h0) ? 8'hF7 : (a == 4'h3) ? 8'h0F : 8'hFF;
    wire  [7:0] exp_rd = mir_q[a] & msk;
    wire  [3:0] exp_oe = mir_q[3][3:0] & ~{1'b0, mir_q[0][7], 1'b0, mir_q[0][6]};
    wire        ctl_wr = bus_req.wr && hit && (a == 4'h0 || a == 4'h3);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Settle count hides the registered lag of the pin enables
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            for (int i = 0; i < 16; i++) mir_q[i] <= (i >= 8) ? 8'hFF : 8'h00;
            st_q <= 2'h3;
        end else begin
            if (bus_req.wr && hit) mir_q[a] <= bus_req.wdata;
            st_q <= ctl_wr ? 2'h0 : (st_q == 2'h3) ? st_q : st_q + 2'h1;
        end
    end
    chk_rd_idle: assert property (!bus_req.rd |=> rd_data == 8'h00)
        else $error("read data not zero without a read");
    chk_rd_unmap: assert property (bus_req.rd && !hit |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    chk_clk_bit3: assert property (bus_req.rd && hit && a == 4'h0 |=> rd_data[3] == 1'b0)
        else $error("clock select bit 3 not zero");
    chk_en_upper: assert property (bus_req.rd && hit && a == 4'h3 |=> rd_data[7:4] == 4'h0)
        else $error("enable upper bits not zero");
    chk_reg_readback: assert property (bus_req.rd && hit && a[3:2] != 2'b01 |=> rd_data == $past(exp_rd))
        else $error("register read back wrong");
    chk_oe_follow: assert property (st_q == 2'h3 |-> wave_oe == exp_oe)
        else $error("pin enable does not follow enables");
    chk_join_free: assert property (mir_q[0][6] [*3] |-> !wave_oe[0])
        else $error("joined high pin still driven");
    chk_reset_quiet: assert property ($rose(rst_b) |-> wave_oe == 4'h0 && rd_data == 8'h00)
        else $error("outputs not quiet after reset");
    cov_join_read: cover property (mir_q[0][7] && bus_req.rd && a == 4'h6 ##1 bus_req.rd && a == 4'h7);
    cov_scaled_run: cover property (st_q == 2'h3 && mir_q[1][7] && wave_oe[3]);
    cov_wave_edge: cover property (wave_oe[1] && $rose(wave_out[1]));
endmodule
bind pwmt_top pwmt_monitor i_pwmt_monitor (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req),
    .rd_data(rd_data), .wave_out(wave_out), .wave_oe(wave_oe));

/* File: tb/tb_pwmt_top.sv */
`timescale 1ns/1ps
module tb_pwmt_top;
    import pwmt_pkg::*;
    logic       clk_sys   = 1'b0;
    logic       rst_b     = 1'b0;
    pwmt_bus_t  bus_req   = '0;
    logic [7:0] rd_data;
    logic [3:0] wave_out;
    logic [3:0] wave_oe;
    logic [7:0] lf        = 8'h13;
    int         error_cnt = 0;
    int         n_tests   = 0;
    pwmt_byte_t v1, v2, h;

    always #50 clk_sys = ~clk_sys;

    pwmt_top i_pwmt_top (.clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req), .rd_data(rd_data),
        .wave_out(wave_out), .wave_oe(wave_oe));

    function automatic int rnd(input int m);
        lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
        return lf % m;
    endfunction

    task automatic wrap_up;
        if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk8(input pwmt_byte_t got, input pwmt_byte_t exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_n(input int got, input int exp);
        n_tests++;
        if (got != exp) begin
            error_cnt++;
            $display("Error at %0t: count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output pwmt_byte_t q);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1 q = rd_data;
    endtask

    // High byte then low byte on consecutive edges, as software must do
    task automatic rd_pair(input logic [7:0] a, output pwmt_byte_t qh, output pwmt_byte_t ql);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.addr <= a + 8'h01;
        #1 qh = rd_data;
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1 ql = rd_data;
    endtask

    // Whole periods are sampled, so the counts do not depend on phase
    task automatic pwm_case(input int ch, sel, pa, pb, sc, per, dty, pol, jn);
        int   c, t, hi, p, nh, nr;
        logic pv;
        wr(8'h60, 8'((jn << (ch >= 2 ? 7 : 6)) | (pa << 4) | pb));
        wr(8'h61, 8'((sel << (4 + ch)) | (jn << (3 + ch)) | (pol << ch)));
        wr(8'h62, 8'(sc));
        wr(8'(8'h68 + ch), 8'(per));
        wr(8'(8'h6C + ch), 8'(dty));
        if (jn != 0) begin
            wr(8'(8'h67 + ch), 8'(per >> 8));
            wr(8'(8'h6B + ch), 8'(dty >> 8));
        end
        wr(8'(8'h64 + ch), 8'h00);
        wr(8'h63, 8'(1 << ch));
        c = (sel != 0) ? (2 << pa) * (sc == 0 ? 256 : sc) : (1 << ((ch >= 2) ? pb : pa));
        t = per + 1;
        hi = (dty == 0 && per > 0) ? (pol ? 0 : t) : (dty >= per) ? (pol ? t : 0) : (pol ? dty : t - dty);
        p = t * c;
        nh = 0;
        nr = 0;
        repeat (3 * p + 4) @(posedge clk_sys);
        #1 pv = wave_out[ch];
        repeat (4 * p) begin
            @(posedge clk_sys);
            #1;
            nh += (wave_out[ch] === 1'b1);
            nr += (wave_out[ch] === 1'b1 && pv === 1'b0);
            pv = wave_out[ch];
        end
        chk_n(nh, 4 * hi * c);
        chk_n(nr, (hi == 0 || hi == t) ? 0 : 4);
        chk8({4'h0, wave_oe}, 8'(1 << ch));
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        #1;
        for (int a = 8'h5F; a <= 8'h70; a++) begin
            rd(a[7:0], v1);
            chk8(v1, (a >= 8'h68 && a <= 8'h6F) ? 8'hFF : 8'h00);
        end
        for (int a = 8'h5F; a <= 8'h70; a++) begin
            v2 = 8'(rnd(256));
            wr(a[7:0], v2);
            rd(a[7:0], v1);
            if (a < 8'h64 || a > 8'h67) chk8(v1, (a < 8'h60 || a > 8'h6F) ? 8'h00 : (a == 8'h60) ? (v2 & 8'hF7)
                : (a == 8'h63) ? (v2 & 8'h0F) : v2);
        end
        // Duty below period so the pin toggles and the tick rate shows in the counts
        for (int k = 0; k < 4; k++) pwm_case(0, 0, k, 0, 1, 2, 1, 1, 0);
        for (int k = 0; k < 8; k++) pwm_case(2, 0, 0, k, 1, 2, 1, 1, 0);
        pwm_case(3, 1, 1, 0, 3, 2, 1, 0, 0);
        pwm_case(0, 1, 0, 0, 0, 2, 1, 1, 0);
        for (int pl = 0; pl < 2; pl++) begin
            pwm_case(1, 0, 0, 0, 1, 3, 0, pl, 0);
            pwm_case(1, 0, 0, 0, 1, 3, 3, pl, 0);
            pwm_case(1, 0, 0, 0, 1, 0, 0, pl, 0);
        end
        for (int i = 0; i < 6; i++) pwm_case(rnd(4), rnd(2), rnd(2), rnd(3), 1 + rnd(3), 1 + rnd(7), rnd(9), rnd(2), 0);
        pwm_case(1, 0, 0, 0, 1, 16'h0103, 16'h0080, 1, 1);
        pwm_case(3, 0, 0, 0, 1, 16'h0102, 16'h0040, 0, 1);
        wr(8'h67, 8'h00);
        rd(8'h67, v1);
        wr(8'h67, 8'h00);
        rd_pair(8'h66, h, v2);
        chk8(v2, v1);
        chk8(h, 8'h00);
        wr(8'h66, 8'hFF);
        rd(8'h66, h);
        chk8(h, 8'h00);
        wrap_up;
    end

    initial begin
        #(90000 * 100);
        error_cnt++;
        wrap_up;
    end
endmodule
